// ===== logic/gpc_port.sv
// What this block does
// - Direction bit one means input
// - Reset leaves every pin an input
// - Output hold reads and writes latch
// - Pin level reads pins, writes latch
// - Open-drain pins drive low only unless a peripheral owns them
// - Analog select resets to all ones
// - Analog input pins read zero
// - Peripheral ownership overrides latch and direction
// - Change caught even across stopped clock
// - Per-pin enable allows change request
// - Bit eleven picks mismatch or edges
// - Mismatch status since last level read
// - Edge flags record armed edges
// - Independent weak pull-up and pull-down bits
// - Set, clear, invert aliases touch ones
`timescale 1ns/1ns
module gpc_port (
	// Clock and synchronous reset
	input wire logic clk,
	input wire logic reset,
	// Register bus, read data one cycle after the strobe
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Pads
	input wire logic [15:0] pin_in,
	output logic [15:0] pin_out,
	output logic [15:0] pin_oe,
	// Peripheral mux, same clock as the bus
	input wire logic [15:0] periph_own,
	input wire logic [15:0] periph_out,
	input wire logic [15:0] periph_oe,
	// Pad ring controls and the change request
	output logic [15:0] weak_pullup_en,
	output logic [15:0] weak_pulldown_en,
	output logic [15:0] analog_mode,
	output logic change_request
);

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	// Bus-visible registers; status and flags live in change logic
	logic [15:0] analog_select_reg; // One = analog pin
	logic [15:0] direction_reg; // One = input
	logic [15:0] output_hold_reg; // Output latch
	logic [15:0] open_drain_select_reg; // One = open drain
	logic edge_sense_select; // Zero = mismatch, one = edges
	logic [15:0] change_enable_pos_reg; // Mismatch or rising arm
	logic [15:0] change_enable_neg_reg; // Falling arm
	logic [15:0] weak_pullup_enable_reg; // Pull-up per pin
	logic [15:0] weak_pulldown_enable_reg; // Pull-down per pin

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	logic [3:0] sel; // Register index
	logic [1:0] op; // Alias within the register
	logic [15:0] wd; // Low half of write data
	logic [15:0] pin_sync; // Synchronised pin levels
	logic [15:0] pin_visible; // Levels as software sees them
	logic [15:0] change_status_reg; // Mismatch status
	logic [15:0] edge_flag_reg; // Edge flags
	logic level_read; // Plain read of the pin level register
	logic flag_wr; // Any write that targets the edge flags
	logic [15:0] flag_val; // Value software wants in the flags
	logic request; // Registered request from change logic

	// Address fields; the two lowest bits are ignored
	assign sel = addr[gpc_pkg::SEL_HI:gpc_pkg::SEL_LO];
	assign op = addr[gpc_pkg::OP_HI:gpc_pkg::OP_LO];
	assign wd = wdata[15:0];

	// ---------------------------------------------------------------
	// Alias helpers
	// ---------------------------------------------------------------

	// Alias arithmetic shared by every writable register except change control
	function automatic logic [15:0] apply_op(
		input logic [15:0] old,
		input logic [1:0] kind,
		input logic [15:0] val
	);
		logic [15:0] res;
		res = val;
		case (kind)
			gpc_pkg::OP_CLR: res = old & ~val;
			gpc_pkg::OP_SET: res = old | val;
			gpc_pkg::OP_INV: res = old ^ val;
			default: res = val;
		endcase
		return res;
	endfunction : apply_op

	// Write hit on one register index, any alias
	function automatic logic hit(input logic [3:0] idx);
		return wr && (sel == idx);
	endfunction : hit

	// ---------------------------------------------------------------
	// Pin input path
	// ---------------------------------------------------------------

	// Pins are asynchronous to clk; only the second flop is read
	// Hazard: a multi-bit pin change may land over two cycles
	gpc_sync #(
		.W(gpc_pkg::PINS)
	) u_sync (
		.clk(clk),
		.reset(reset),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	// Analog inputs read low whatever the pin voltage
	assign pin_visible = pin_sync &
		~(analog_select_reg & direction_reg);

	// Only a plain read restarts mismatch tracking
	assign level_read = rd && (sel == gpc_pkg::IDX_PIN_LEVEL) &&
		(op == gpc_pkg::OP_BASE);
	// Alias resolved here so an edge in the same cycle still wins
	assign flag_wr = hit(gpc_pkg::IDX_EDGE_FLAG);
	assign flag_val = apply_op(edge_flag_reg, op, wd);

	// ---------------------------------------------------------------
	// Change notice
	// ---------------------------------------------------------------

	// Compares against held state, so a change made while the clock
	// was stopped reaches status or flags at the third edge after it restarts
	gpc_change #(
		.W(gpc_pkg::PINS)
	) u_change (
		.clk(clk),
		.reset(reset),
		.level(pin_sync),
		.en_pos(change_enable_pos_reg),
		.en_neg(change_enable_neg_reg),
		.edge_mode(edge_sense_select),
		.level_read(level_read),
		.flag_wr(flag_wr),
		.flag_val(flag_val),
		.status(change_status_reg),
		.flag(edge_flag_reg),
		.request(request)
	);

	// Straight from the request flop inside the change logic
	assign change_request = request;

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------

	// Analog select starts all analog so no input buffer floats
	always_ff @(posedge clk) begin
		if (reset) begin
			analog_select_reg <= gpc_pkg::ANALOG_RESET;
		end else if (hit(gpc_pkg::IDX_ANALOG)) begin
			analog_select_reg <= apply_op(analog_select_reg, op, wd);
		end
	end

	// Direction; every reset makes all pins inputs
	always_ff @(posedge clk) begin
		if (reset) begin
			direction_reg <= gpc_pkg::DIRECTION_RESET;
		end else if (hit(gpc_pkg::IDX_DIRECTION)) begin
			direction_reg <= apply_op(direction_reg, op, wd);
		end
	end

	// Output latch, written by its own address or the pin address
	always_ff @(posedge clk) begin
		if (reset) begin
			output_hold_reg <= gpc_pkg::ZERO_RESET;
		end else if (hit(gpc_pkg::IDX_OUTPUT_HOLD)) begin
			output_hold_reg <= apply_op(output_hold_reg, op, wd);
		end else if (hit(gpc_pkg::IDX_PIN_LEVEL)) begin
			output_hold_reg <= apply_op(output_hold_reg, op, wd);
		end
	end

	// Open-drain select
	always_ff @(posedge clk) begin
		if (reset) begin
			open_drain_select_reg <= gpc_pkg::ZERO_RESET;
		end else if (hit(gpc_pkg::IDX_OPEN_DRAIN)) begin
			open_drain_select_reg <=
				apply_op(open_drain_select_reg, op, wd);
		end
	end

	// Change control; only the edge-sense bit is stored
	// Other control bits are dropped and read back as zero
	always_ff @(posedge clk) begin
		if (reset) begin
			edge_sense_select <= 1'b0;
		end else if (hit(gpc_pkg::IDX_CHANGE_CTRL)) begin
			case (op)
				gpc_pkg::OP_CLR: edge_sense_select <= edge_sense_select &
					~wdata[gpc_pkg::EDGE_SENSE_BIT];
				gpc_pkg::OP_SET: edge_sense_select <= edge_sense_select |
					wdata[gpc_pkg::EDGE_SENSE_BIT];
				gpc_pkg::OP_INV: edge_sense_select <= edge_sense_select ^
					wdata[gpc_pkg::EDGE_SENSE_BIT];
				default: edge_sense_select <=
					wdata[gpc_pkg::EDGE_SENSE_BIT];
			endcase
		end
	end

	// Positive or mismatch enables
	always_ff @(posedge clk) begin
		if (reset) begin
			change_enable_pos_reg <= gpc_pkg::ZERO_RESET;
		end else if (hit(gpc_pkg::IDX_ENABLE_POS)) begin
			change_enable_pos_reg <=
				apply_op(change_enable_pos_reg, op, wd);
		end
	end

	// Negative edge enables
	always_ff @(posedge clk) begin
		if (reset) begin
			change_enable_neg_reg <= gpc_pkg::ZERO_RESET;
		end else if (hit(gpc_pkg::IDX_ENABLE_NEG)) begin
			change_enable_neg_reg <=
				apply_op(change_enable_neg_reg, op, wd);
		end
	end

	// Weak pull-up; software must keep it off on outputs
	always_ff @(posedge clk) begin
		if (reset) begin
			weak_pullup_enable_reg <= gpc_pkg::ZERO_RESET;
		end else if (hit(gpc_pkg::IDX_PULLUP)) begin
			weak_pullup_enable_reg <=
				apply_op(weak_pullup_enable_reg, op, wd);
		end
	end

	// Weak pull-down, independent of the pull-up
	always_ff @(posedge clk) begin
		if (reset) begin
			weak_pulldown_enable_reg <= gpc_pkg::ZERO_RESET;
		end else if (hit(gpc_pkg::IDX_PULLDOWN)) begin
			weak_pulldown_enable_reg <=
				apply_op(weak_pulldown_enable_reg, op, wd);
		end
	end

	// ---------------------------------------------------------------
	// Pin drive
	// ---------------------------------------------------------------

	// Registered drive adds one cycle after a latch or direction write
	// Limitation: analog select does not gate the output driver
	always_ff @(posedge clk) begin
		if (reset) begin
			// Pads start undriven, matching all-input direction
			pin_out <= 16'h0000;
			pin_oe <= 16'h0000;
		end else begin
			// Peripheral bits bypass latch and direction entirely
			pin_out <= (periph_own & periph_out) |
				(~periph_own & output_hold_reg &
				~open_drain_select_reg);
			// Open drain enables only while the latch holds zero
			pin_oe <= (periph_own & periph_oe) |
				(~periph_own & ~direction_reg &
				(~open_drain_select_reg | ~output_hold_reg));
		end
	end

	// Pull and analog controls out to the pad ring
	// Copies are registered so every top output leaves a flop
	always_ff @(posedge clk) begin
		if (reset) begin
			weak_pullup_en <= 16'h0000;
			weak_pulldown_en <= 16'h0000;
			analog_mode <= gpc_pkg::ANALOG_RESET;
		end else begin
			weak_pullup_en <= weak_pullup_enable_reg;
			weak_pulldown_en <= weak_pulldown_enable_reg;
			analog_mode <= analog_select_reg;
		end
	end

	// ---------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------

	// Data one cycle after the strobe; aliases and holes read zero
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata <= 32'h00000000;
		end else if (rd && (op == gpc_pkg::OP_BASE)) begin
			// Clear first so unused upper bits read zero
			rdata <= 32'h00000000;
			case (sel)
				gpc_pkg::IDX_ANALOG: rdata[15:0] <= analog_select_reg;
				gpc_pkg::IDX_DIRECTION: rdata[15:0] <= direction_reg;
				// Pins, not the latch; analog inputs masked
				gpc_pkg::IDX_PIN_LEVEL: rdata[15:0] <= pin_visible;
				gpc_pkg::IDX_OUTPUT_HOLD:
					rdata[15:0] <= output_hold_reg;
				gpc_pkg::IDX_OPEN_DRAIN:
					rdata[15:0] <= open_drain_select_reg;
				// Only the edge-sense bit has storage
				gpc_pkg::IDX_CHANGE_CTRL:
					rdata[gpc_pkg::EDGE_SENSE_BIT] <= edge_sense_select;
				gpc_pkg::IDX_ENABLE_POS:
					rdata[15:0] <= change_enable_pos_reg;
				// Status is read only; writes to it are dropped
				gpc_pkg::IDX_STATUS:
					rdata[15:0] <= change_status_reg;
				gpc_pkg::IDX_PULLUP:
					rdata[15:0] <= weak_pullup_enable_reg;
				gpc_pkg::IDX_PULLDOWN:
					rdata[15:0] <= weak_pulldown_enable_reg;
				gpc_pkg::IDX_ENABLE_NEG:
					rdata[15:0] <= change_enable_neg_reg;
				gpc_pkg::IDX_EDGE_FLAG:
					rdata[15:0] <= edge_flag_reg;
				// Unmapped indices read zero
				default: rdata <= 32'h00000000;
			endcase
		end else begin
			// Alias reads and idle cycles give zero
			rdata <= 32'h00000000;
		end
	end

endmodule : gpc_port

// ===== common/gpc_pkg.sv
// ---------------------------------------------------------------
// Shared constants for the port block
// ---------------------------------------------------------------
package gpc_pkg;

	// Port shape
	localparam int PINS = 16; // Pins in one port
	localparam int ADDR_W = 8; // Register address width
	localparam int DATA_W = 32; // Register data width

	// ---------------------------------------------------------------
	// Register map: addr[7:4] picks the register, addr[3:2] the alias
	// ---------------------------------------------------------------
	localparam logic [3:0] IDX_ANALOG = 4'h0; // Analog select
	localparam logic [3:0] IDX_DIRECTION = 4'h1; // Direction
	localparam logic [3:0] IDX_PIN_LEVEL = 4'h2; // Pin level
	localparam logic [3:0] IDX_OUTPUT_HOLD = 4'h3; // Output hold
	localparam logic [3:0] IDX_OPEN_DRAIN = 4'h4; // Open-drain select
	localparam logic [3:0] IDX_CHANGE_CTRL = 4'h5; // Change control
	localparam logic [3:0] IDX_ENABLE_POS = 4'h6; // Change enable pos
	localparam logic [3:0] IDX_STATUS = 4'h7; // Change status
	localparam logic [3:0] IDX_PULLUP = 4'h8; // Weak pull-up enable
	localparam logic [3:0] IDX_PULLDOWN = 4'h9; // Weak pull-down enable
	localparam logic [3:0] IDX_ENABLE_NEG = 4'ha; // Change enable neg
	localparam logic [3:0] IDX_EDGE_FLAG = 4'hb; // Edge flags

	// Alias selectors within one register's block
	localparam logic [1:0] OP_BASE = 2'h0; // Plain access
	localparam logic [1:0] OP_CLR = 2'h1; // Clear ones
	localparam logic [1:0] OP_SET = 2'h2; // Set ones
	localparam logic [1:0] OP_INV = 2'h3; // Invert ones

	// Field positions
	localparam int SEL_HI = 7; // Register index top bit
	localparam int SEL_LO = 4; // Register index low bit
	localparam int OP_HI = 3; // Alias top bit
	localparam int OP_LO = 2; // Alias low bit
	localparam int EDGE_SENSE_BIT = 11; // Edge-sense select in control

	// Reset values
	localparam logic [15:0] ANALOG_RESET = 16'hffff; // All analog
	localparam logic [15:0] DIRECTION_RESET = 16'hffff; // All inputs
	localparam logic [15:0] ZERO_RESET = 16'h0000; // Others clear

endpackage : gpc_pkg

// ===== logic/gpc_sync.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Two-flop synchroniser for a bus of independent levels
// ---------------------------------------------------------------
module gpc_sync #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] stage1; // Metastable stage, read only by stage 2

	// Each bit is its own level, so no bus coherency is promised
	always_ff @(posedge clk) begin
		if (reset) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule : gpc_sync

// ===== logic/gpc_change.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Change notice: mismatch status, edge flags, request
// ---------------------------------------------------------------
module gpc_change #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] level,
	input wire logic [W-1:0] en_pos,
	input wire logic [W-1:0] en_neg,
	input wire logic edge_mode,
	input wire logic level_read,
	input wire logic flag_wr,
	input wire logic [W-1:0] flag_val,
	output logic [W-1:0] status,
	output logic [W-1:0] flag,
	output logic request
);

	logic [W-1:0] prev; // Last sample, for edges
	logic [W-1:0] ref_level; // Level seen at the last pin read
	logic [W-1:0] rise; // Rising edges this cycle
	logic [W-1:0] fall; // Falling edges this cycle
	logic [W-1:0] armed; // Edges that qualify

	assign rise = level & ~prev;
	assign fall = ~level & prev;
	assign armed = (rise & en_pos) | (fall & en_neg);

	// Previous sample; held value keeps a change seen after a stall
	always_ff @(posedge clk) begin
		if (reset) begin
			prev <= '0;
		end else begin
			prev <= level;
		end
	end

	// Reference reloads on a read of the pin level register
	always_ff @(posedge clk) begin
		if (reset) begin
			ref_level <= '0;
		end else if (level_read) begin
			ref_level <= level;
		end
	end

	// Sticky mismatch; the read returns this same level, so none lost
	always_ff @(posedge clk) begin
		if (reset) begin
			status <= '0;
		end else if (level_read) begin
			status <= '0;
		end else if (!edge_mode) begin
			status <= status | (en_pos & (level ^ ref_level));
		end
	end

	// Edge flags: software value, then new edges win over the clear
	always_ff @(posedge clk) begin
		if (reset) begin
			flag <= '0;
		end else begin
			flag <= (flag_wr ? flag_val : flag) |
				(edge_mode ? armed : '0);
		end
	end

	// One request per port, from enabled pending bits
	always_ff @(posedge clk) begin
		if (reset) begin
			request <= 1'b0;
		end else if (edge_mode) begin
			request <= |(flag & (en_pos | en_neg));
		end else begin
			request <= |(status & en_pos);
		end
	end

endmodule : gpc_change

// ===== verif/gpc_pins.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Far side: pads with outside drivers and weak pulls
// ---------------------------------------------------------------
module gpc_pins (
	input wire logic clk,
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe,
	input wire logic [15:0] pull_up,
	input wire logic [15:0] pull_dn,
	input wire logic [15:0] ext_en,
	input wire logic [15:0] ext_val,
	output logic [15:0] pin_in
);
	logic [15:0] float_val = 16'h5a5a; // Level of an undriven pad
	// Toggle so a floating pad never looks settled
	always @(posedge clk) begin
		float_val <= ~float_val;
	end
	// Our driver first, then the outside part, then pulls
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (pin_oe[i]) begin
				pin_in[i] = pin_out[i];
			end else if (ext_en[i]) begin
				pin_in[i] = ext_val[i];
			end else if (pull_up[i]) begin
				pin_in[i] = 1'b1;
			end else if (pull_dn[i]) begin
				pin_in[i] = 1'b0;
			end else begin
				pin_in[i] = float_val[i];
			end
		end
	end
endmodule : gpc_pins

// ===== verif/gpc_port_props.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------
module gpc_port_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic [15:0] pin_in,
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe,
	input wire logic [15:0] periph_own,
	input wire logic [15:0] periph_out,
	input wire logic [15:0] periph_oe,
	input wire logic [15:0] weak_pullup_en,
	input wire logic [15:0] weak_pulldown_en,
	input wire logic [15:0] analog_mode,
	input wire logic change_request
);
	logic edge_mode; // Follows base writes of change control only
	// Track edge-sense select from the bus
	always_ff @(posedge clk) begin
		if (reset) begin
			edge_mode <= 1'b0;
		end else if (wr && addr == 8'h50) begin
			edge_mode <= wdata[11];
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	property p_alias_rd;
		rd && addr[3:2] != 2'h0 |=> rdata == 32'h0;
	endproperty
	a_alias_rd: assert property (p_alias_rd)
		else $error("alias read returned data");
	property p_reset_val;
		$fell(reset) |-> pin_oe == 16'h0 && analog_mode == 16'hffff;
	endproperty
	a_reset_val: assert property (p_reset_val)
		else $error("wrong pad state after reset");
	property p_own;
		!$past(reset) |-> (((pin_oe ^ $past(periph_oe)) |
			(pin_out ^ $past(periph_out))) & $past(periph_own)) == 16'h0;
	endproperty
	a_own: assert property (p_own)
		else $error("owned pad not following peripheral");
	property p_sync;
		$stable(pin_in) [*4] ##0 (rd && addr == 8'h20 &&
			analog_mode == 16'h0) |=> rdata == {16'h0, $past(pin_in)};
	endproperty
	a_sync: assert property (p_sync)
		else $error("pin level read mismatch");
	property p_pull;
		wr && addr == 8'h80 |=> ##1 weak_pullup_en == $past(wdata[15:0], 2);
	endproperty
	a_pull: assert property (p_pull)
		else $error("pull-up enable not written");
	property p_ana_clr;
		wr && addr == 8'h04 |=> ##1
			analog_mode == ($past(analog_mode) & ~$past(wdata[15:0], 2));
	endproperty
	a_ana_clr: assert property (p_ana_clr)
		else $error("analog clear alias wrong");
	property p_mis_clr;
		!edge_mode && $stable(pin_in) [*4] ##0 (rd && addr == 8'h20)
			|=> ##2 !change_request;
	endproperty
	a_mis_clr: assert property (p_mis_clr)
		else $error("request kept after level read");
	// A write one cycle back may still be draining through the request
	property p_edge_hold;
		edge_mode && change_request && !wr && !$past(wr) |=> change_request;
	endproperty
	a_edge_hold: assert property (p_edge_hold)
		else $error("edge request dropped without write");
endmodule : gpc_port_chk
bind gpc_port gpc_port_chk u_chk (.clk(clk), .reset(reset), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in),
	.pin_out(pin_out), .pin_oe(pin_oe), .periph_own(periph_own),
	.periph_out(periph_out), .periph_oe(periph_oe),
	.weak_pullup_en(weak_pullup_en), .weak_pulldown_en(weak_pulldown_en),
	.analog_mode(analog_mode), .change_request(change_request));

// ===== verif/gpc_port_bench.sv
`timescale 1ns/1ns
module gpc_port_bench;
	logic clk = 1'b0; // 250 MHz
	logic reset = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic [15:0] pin_in, pin_out, pin_oe, pull_up, pull_dn, analog_mode;
	logic [15:0] periph_own = 16'h0, periph_out = 16'h0, periph_oe = 16'h0;
	logic [15:0] ext_en = 16'hffff, ext_val = 16'h0; // Outside drivers
	logic change_request;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0; // Hang guard
	always #2 clk = ~clk;
	gpc_port DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .periph_own(periph_own), .periph_out(periph_out),
		.periph_oe(periph_oe), .weak_pullup_en(pull_up),
		.weak_pulldown_en(pull_dn), .analog_mode(analog_mode),
		.change_request(change_request));
	gpc_pins u_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pull_up(pull_up), .pull_dn(pull_dn), .ext_en(ext_en),
		.ext_val(ext_val), .pin_in(pin_in));
	// ---------------------------------------------------------------
	// Shared bus and compare tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : idle
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= {16'h0, d};
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(rdata, {16'h0, e});
	endtask : rd_chk
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		rd_chk(8'h00, 16'hffff);
		rd_chk(8'h10, 16'hffff);
		check(pin_oe, 32'h0);
		rd_chk(8'hc0, 16'h0);
		$display("reset values done");
	endtask : t_reset
	task automatic t_drive();
		wr_reg(8'h04, 16'hffff);
		wr_reg(8'h30, 16'ha5c3);
		rd_chk(8'h30, 16'ha5c3);
		wr_reg(8'h10, 16'h0000);
		idle(2);
		check(pin_oe, 32'hffff);
		check(pin_out, 32'ha5c3);
		idle(3);
		rd_chk(8'h20, 16'ha5c3);
		wr_reg(8'h20, 16'h1234);
		rd_chk(8'h30, 16'h1234);
		wr_reg(8'h38, 16'h00f0);
		rd_chk(8'h30, 16'h12f4);
		wr_reg(8'h3c, 16'hffff);
		rd_chk(8'h30, 16'hed0b);
		rd_chk(8'h38, 16'h0);
		$display("drive and latch done");
	endtask : t_drive
	// Open drain, then peripheral takeover on the low byte
	task automatic t_od_own();
		wr_reg(8'h30, 16'h0f0f);
		wr_reg(8'h40, 16'h00ff);
		idle(2);
		check(pin_oe, 32'hfff0);
		check(pin_out, 32'h0f00);
		wr_reg(8'h40, 16'h0000);
		periph_own <= 16'h00ff;
		periph_oe <= 16'h000f;
		periph_out <= 16'h0005;
		idle(3);
		check(pin_oe, 32'hff0f);
		check(pin_out, 32'h0f05);
		periph_own <= 16'h0000;
		$display("open drain and ownership done");
	endtask : t_od_own
	// Pulls are checked through the pads with outside drivers released
	task automatic t_analog();
		wr_reg(8'h10, 16'hffff);
		ext_val <= 16'hffff;
		wr_reg(8'h00, 16'h00ff);
		idle(3);
		check(analog_mode, 32'h00ff);
		rd_chk(8'h20, 16'hff00);
		wr_reg(8'h80, 16'h00f0);
		wr_reg(8'h90, 16'h0f00);
		idle(2);
		check(pull_up, 32'h00f0);
		check(pull_dn, 32'h0f00);
		wr_reg(8'h00, 16'h0000);
		ext_en <= 16'hf00f;
		idle(3);
		rd_chk(8'h20, 16'hf0ff);
		ext_en <= 16'hffff;
		wr_reg(8'h80, 16'h0000);
		wr_reg(8'h90, 16'h0000);
		$display("analog and pulls done");
	endtask : t_analog
	task automatic t_mismatch();
		ext_val <= 16'h0000;
		wr_reg(8'h50, 16'h0000);
		wr_reg(8'h60, 16'h0001);
		idle(4);
		rd_chk(8'h20, 16'h0000);
		ext_val <= 16'h0002;
		idle(6);
		check(change_request, 32'h0);
		rd_chk(8'h20, 16'h0002);
		ext_val <= 16'h0003;
		idle(6);
		check(change_request, 32'h1);
		rd_chk(8'h70, 16'h0001);
		rd_chk(8'h20, 16'h0003);
		idle(3);
		check(change_request, 32'h0);
		rd_chk(8'h70, 16'h0000);
		$display("mismatch mode done");
	endtask : t_mismatch
	task automatic t_edge();
		ext_val <= 16'h0000;
		wr_reg(8'h60, 16'h0002);
		wr_reg(8'ha0, 16'h0004);
		wr_reg(8'h50, 16'h0800);
		wr_reg(8'hb0, 16'h0000);
		ext_val <= 16'h0006;
		idle(6);
		rd_chk(8'hb0, 16'h0002);
		check(change_request, 32'h1);
		ext_val <= 16'h0000;
		idle(6);
		rd_chk(8'hb0, 16'h0006);
		wr_reg(8'hb0, 16'h0000);
		idle(3);
		check(change_request, 32'h0);
		rd_chk(8'hb0, 16'h0000);
		$display("edge mode done");
	endtask : t_edge
	// Reset in mid-run must bring back inputs and analog pins
	task automatic t_again();
		wr_reg(8'h10, 16'h0000);
		idle(2);
		check(pin_oe, 32'hffff);
		@(posedge clk);
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rd_chk(8'h10, 16'hffff);
		check(pin_oe, 32'h0);
		rd_chk(8'h00, 16'hffff);
		check(change_request, 32'h0);
		$display("second reset done");
	endtask : t_again
	task automatic results();
		$display("checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results
	// Run takes about 160 cycles; far below this ceiling
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			results();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_drive();
		t_od_own();
		t_analog();
		t_mismatch();
		t_edge();
		t_again();
		results();
	end
endmodule : gpc_port_bench
